// ===== hdl/mux_regs_pkg.sv
/*
  Constants, field positions, timing counts and shared types of the
  two-channel bus multiplexer register bank.
  Assumes a single 50 MHz system clock that samples every bus pin.
*/
package mux_regs_pkg;

  // register offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_ACCEL  = 8'h01;
  localparam logic [7:0] REG_CONFIG = 8'h02;
  localparam logic [7:0] REG_SWITCH = 8'h03;

  // status register fields
  localparam int ST_CONN_BIT    = 7;
  localparam int ST_F1_BIT      = 6;
  localparam int ST_F2_BIT      = 5;
  localparam int ST_NOFAIL_BIT  = 2;
  localparam int ST_LATCH_BIT   = 1;
  localparam int ST_RT_BIT      = 0;

  // booster, configuration and switch register fields
  localparam int ACC_UP_BIT     = 7;
  localparam int ACC_DN_BIT     = 6;
  localparam int CFG_CONN_BIT   = 5;
  localparam int CFG_MASS_BIT   = 2;
  localparam int CFG_SEL_HI_BIT = 1;
  localparam int CFG_SEL_LO_BIT = 0;
  localparam int SW_FET1_BIT    = 7;
  localparam int SW_FET2_BIT    = 6;
  localparam int SW_LS1_BIT     = 3;
  localparam int SW_LS2_BIT     = 2;

  // special bus addresses
  localparam logic [6:0] ARA_ADDR  = 7'h0c;
  localparam logic [6:0] MASS_ADDR = 7'h5e;

  // stuck-low timeout selections and durations
  localparam logic [1:0] TMO_OFF    = 2'h0;
  localparam logic [1:0] TMO_SEL_30 = 2'h1;
  localparam logic [1:0] TMO_SEL_15 = 2'h2;
  localparam int CLK_MHZ     = 50;
  localparam int TMO_30_US   = 30000;
  localparam int TMO_15_US   = 15000;
  localparam int TMO_7P5_US  = 7500;
  localparam int TMO_30_CYC  = TMO_30_US * CLK_MHZ;
  localparam int TMO_15_CYC  = TMO_15_US * CLK_MHZ;
  localparam int TMO_7P5_CYC = TMO_7P5_US * CLK_MHZ;

  // pin synchroniser width and idle value (bus high, enable low)
  localparam int              PIN_SYNC_W     = 15;
  localparam logic [14:0]     PIN_SYNC_RESET = 15'h00ff;

  // writable control state; fet[0] is channel one
  typedef struct packed {
    logic       acc_up;
    logic       acc_dn;
    logic       conn_any;
    logic       mass_wr;
    logic       stuck_timeout_sel_hi;
    logic       stuck_timeout_sel_lo;
    logic [1:0] fet;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{acc_up: 1'b0, acc_dn: 1'b0, conn_any: 1'b0, mass_wr: 1'b1,
                                   stuck_timeout_sel_hi: 1'b0, stuck_timeout_sel_lo: 1'b0, fet: 2'b00};

  // serial slave states, gray along idle-address-ack-receive
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b011,
    ST_RX   = 3'b010,
    ST_RACK = 3'b110,
    ST_TX   = 3'b111,
    ST_TACK = 3'b101,
    ST_SKIP = 3'b100
  } slave_state_t;

endpackage

// ===== hdl/bus_mux_status_control_regs.sv
/*
  Register bank, serial slave and fault signalling of a two-channel bus
  multiplexer. Assumes all pins are asynchronous to CLK_I and are sampled by it;
  the upstream bus runs far slower than CLK_I. Open-drain pins are split into
  output value and output enable; the board resolves the wire.
*/
`timescale 1ns/1ns
module bus_mux_status_control_regs #(
  parameter int         TMO_30_CYC  = mux_regs_pkg::TMO_30_CYC,
  parameter int         TMO_15_CYC  = mux_regs_pkg::TMO_15_CYC,
  parameter int         TMO_7P5_CYC = mux_regs_pkg::TMO_7P5_CYC,
  parameter logic [6:0] ADDR_BASE   = 7'h40
) (
  input  wire logic       CLK_I,
  input  wire logic       RESET_I,
  input  wire logic       ENABLE_I,
  input  wire logic       UPSTREAM_CLOCK_LINE_I,
  input  wire logic       UPSTREAM_DATA_LINE_I,
  output logic            UPSTREAM_DATA_LINE_O,
  output logic            UPSTREAM_DATA_LINE_OE_O,
  input  wire logic       CHAN_ONE_FAULT_IN_N_I,
  input  wire logic       CHAN_TWO_FAULT_IN_N_I,
  input  wire logic       CHAN_ONE_DATA_LINE_I,
  input  wire logic       CHAN_ONE_CLOCK_LINE_I,
  input  wire logic       CHAN_TWO_DATA_LINE_I,
  input  wire logic       CHAN_TWO_CLOCK_LINE_I,
  input  wire logic [5:0] SLAVE_ADDR_SELECT_I,
  output logic            FAULT_N_O,
  output logic            FAULT_N_OE_O,
  output logic            READY_O,
  output logic            READY_OE_O,
  output logic [1:0]      CHAN_SWITCH_O,
  output logic            ACCEL_UP_O,
  output logic            ACCEL_DOWN_O
);

  localparam int TMO_W = $clog2(TMO_30_CYC + 1);

  // three-level pin code: 00 grounded, 11 tied high, otherwise floating
  function automatic logic [6:0] trit(input logic [1:0] code);
    logic [6:0] val;
    val = (code == 2'b00) ? 7'h00 : (code == 2'b11) ? 7'h02 : 7'h01;
    return val;
  endfunction

  logic [14:0]                  pin_vec;
  logic [14:0]                  sync1_reg;
  logic [14:0]                  sync2_reg;
  logic                         scl_d_reg;
  logic                         sda_d_reg;
  logic                         en_s, scl_s, sda_s, f1_s, f2_s;
  logic [1:0]                   lstate;
  logic [5:0]                   adr_s;
  logic                         reg_rst;
  logic                         scl_rise, scl_fall, start_cond, stop_cond;
  logic [6:0]                   own_addr;
  logic                         own_hit, ara_hit, mass_hit, addr_hit;
  mux_regs_pkg::slave_state_t   state_reg, state_next;
  logic [3:0]                   bitcnt_reg, bitcnt_next;
  logic [7:0]                   sr_reg, sr_next;
  logic [7:0]                   ptr_reg, ptr_next;
  logic                         first_reg, first_next;
  logic                         rw_reg, rw_next;
  logic                         ara_reg, ara_next;
  logic                         oe_reg, oe_next;
  logic                         wr_stb, ara_won;
  mux_regs_pkg::ctrl_t          ctrl_reg, ctrl_next;
  logic                         fail_set;
  logic                         fail_reg, fail_next;
  logic                         latch_reg, latch_next;
  logic                         alert_reg, alert_next;
  logic                         fault_oe_reg;
  logic [TMO_W-1:0]             tmo_cnt_reg, tmo_cnt_next, tmo_limit;
  logic                         tmo_rt_reg, tmo_rt_next, tmo_hit, tmo_clr, tmo_on;
  logic                         wr_status, wr_switch;
  logic [7:0]                   status_byte, accel_byte, config_byte, switch_byte, rd_data, tx_byte;

  // two-flop synchroniser for every pin, then edge history for the bus
  assign pin_vec = {SLAVE_ADDR_SELECT_I, ENABLE_I, UPSTREAM_CLOCK_LINE_I, UPSTREAM_DATA_LINE_I,
                    CHAN_ONE_FAULT_IN_N_I, CHAN_TWO_FAULT_IN_N_I, CHAN_ONE_DATA_LINE_I,
                    CHAN_ONE_CLOCK_LINE_I, CHAN_TWO_DATA_LINE_I, CHAN_TWO_CLOCK_LINE_I};
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      sync1_reg <= mux_regs_pkg::PIN_SYNC_RESET;
      sync2_reg <= mux_regs_pkg::PIN_SYNC_RESET;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      sync1_reg <= pin_vec;
      sync2_reg <= sync1_reg;
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // synchronised pin names and bus conditions
  assign adr_s      = sync2_reg[14:9];
  assign en_s       = sync2_reg[8];
  assign scl_s      = sync2_reg[7];
  assign sda_s      = sync2_reg[6];
  assign f1_s       = sync2_reg[5];
  assign f2_s       = sync2_reg[4];
  assign lstate[0]  = sync2_reg[3] & sync2_reg[2];
  assign lstate[1]  = sync2_reg[1] & sync2_reg[0];
  assign reg_rst    = RESET_I | ~en_s;
  assign scl_rise   = scl_s & ~scl_d_reg;
  assign scl_fall   = ~scl_s & scl_d_reg;
  assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_cond  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // address match: own strap address, alert response, mass write
  assign own_addr = 7'(ADDR_BASE + 7'(7'h09 * trit(adr_s[5:4])) + 7'(7'h03 * trit(adr_s[3:2]))
                    + trit(adr_s[1:0]));
  assign own_hit  = (sr_reg[7:1] == own_addr);
  assign ara_hit  = (sr_reg[7:1] == mux_regs_pkg::ARA_ADDR) & sr_reg[0] & fault_oe_reg;
  assign mass_hit = (sr_reg[7:1] == mux_regs_pkg::MASS_ADDR) & ~sr_reg[0] & ctrl_reg.mass_wr;
  assign addr_hit = own_hit | ara_hit | mass_hit;

  // serial slave: sample on clock rise, drive data after clock fall
  always_comb begin
    state_next  = state_reg;
    bitcnt_next = bitcnt_reg;
    sr_next     = sr_reg;
    ptr_next    = ptr_reg;
    first_next  = first_reg;
    rw_next     = rw_reg;
    ara_next    = ara_reg;
    oe_next     = oe_reg;
    wr_stb      = 1'b0;
    ara_won     = 1'b0;
    if (start_cond) begin
      state_next  = mux_regs_pkg::ST_ADDR;
      bitcnt_next = 4'h0;
      oe_next     = 1'b0;
    end else if (stop_cond) begin
      state_next = mux_regs_pkg::ST_IDLE;
      oe_next    = 1'b0;
    end else begin
      unique case (state_reg)
        mux_regs_pkg::ST_IDLE, mux_regs_pkg::ST_SKIP: begin
          oe_next = 1'b0;
        end
        mux_regs_pkg::ST_ADDR, mux_regs_pkg::ST_RX: begin
          if (scl_rise) begin
            sr_next     = {sr_reg[6:0], sda_s};
            bitcnt_next = bitcnt_reg + 4'h1;
          end else if (scl_fall && bitcnt_reg == 4'h8) begin
            if (state_reg == mux_regs_pkg::ST_RX) begin
              state_next = mux_regs_pkg::ST_RACK;
              oe_next    = 1'b1;
              first_next = 1'b0;
              wr_stb     = ~first_reg;
              ptr_next   = first_reg ? sr_reg : ptr_reg + 8'h01;
            end else if (addr_hit) begin
              state_next = mux_regs_pkg::ST_AACK;
              oe_next    = 1'b1;
              rw_next    = sr_reg[0];
              ara_next   = ara_hit;
              first_next = 1'b1;
            end else begin
              state_next = mux_regs_pkg::ST_SKIP;
            end
          end
        end
        mux_regs_pkg::ST_AACK, mux_regs_pkg::ST_RACK, mux_regs_pkg::ST_TACK: begin
          if (state_reg == mux_regs_pkg::ST_TACK && scl_rise && sda_s) begin
            state_next = mux_regs_pkg::ST_SKIP;                       // master nack ends the read
          end else if (scl_fall) begin
            bitcnt_next = 4'h0;
            if (state_reg == mux_regs_pkg::ST_RACK || !rw_reg) begin
              state_next = mux_regs_pkg::ST_RX;
              oe_next    = 1'b0;
            end else begin
              state_next = mux_regs_pkg::ST_TX;
              sr_next    = tx_byte;
              oe_next    = ~tx_byte[7];
            end
          end
        end
        mux_regs_pkg::ST_TX: begin
          if (scl_rise) begin
            bitcnt_next = bitcnt_reg + 4'h1;
            if (ara_reg && !oe_reg && !sda_s) begin
              state_next = mux_regs_pkg::ST_SKIP;                     // lost alert arbitration
            end
          end else if (scl_fall) begin
            if (bitcnt_reg == 4'h8) begin
              state_next = mux_regs_pkg::ST_TACK;
              oe_next    = 1'b0;
              ara_won    = ara_reg;
              ptr_next   = ptr_reg + 8'h01;
            end else begin
              sr_next = {sr_reg[6:0], 1'b0};
              oe_next = ~sr_reg[6];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (reg_rst) begin
      state_reg  <= mux_regs_pkg::ST_IDLE;
      bitcnt_reg <= 4'h0;
      sr_reg     <= 8'h00;
      ptr_reg    <= 8'h00;
      first_reg  <= 1'b0;
      rw_reg     <= 1'b0;
      ara_reg    <= 1'b0;
      oe_reg     <= 1'b0;
    end else begin
      state_reg  <= state_next;
      bitcnt_reg <= bitcnt_next;
      sr_reg     <= sr_next;
      ptr_reg    <= ptr_next;
      first_reg  <= first_next;
      rw_reg     <= rw_next;
      ara_reg    <= ara_next;
      oe_reg     <= oe_next;
    end
  end

  // read view of the registers; unused bits read zero
  always_comb begin
    status_byte = 8'h00;
    accel_byte  = 8'h00;
    config_byte = 8'h00;
    switch_byte = 8'h00;
    status_byte[mux_regs_pkg::ST_CONN_BIT]   = |ctrl_reg.fet;
    status_byte[mux_regs_pkg::ST_F1_BIT]     = f1_s;
    status_byte[mux_regs_pkg::ST_F2_BIT]     = f2_s;
    status_byte[mux_regs_pkg::ST_NOFAIL_BIT] = ~fail_reg;
    status_byte[mux_regs_pkg::ST_LATCH_BIT]  = latch_reg;
    status_byte[mux_regs_pkg::ST_RT_BIT]     = tmo_rt_reg;
    accel_byte[mux_regs_pkg::ACC_UP_BIT]     = ctrl_reg.acc_up;
    accel_byte[mux_regs_pkg::ACC_DN_BIT]     = ctrl_reg.acc_dn;
    config_byte[mux_regs_pkg::CFG_CONN_BIT]  = ctrl_reg.conn_any;
    config_byte[mux_regs_pkg::CFG_MASS_BIT]  = ctrl_reg.mass_wr;
    config_byte[mux_regs_pkg::CFG_SEL_HI_BIT] = ctrl_reg.stuck_timeout_sel_hi;
    config_byte[mux_regs_pkg::CFG_SEL_LO_BIT] = ctrl_reg.stuck_timeout_sel_lo;
    switch_byte[mux_regs_pkg::SW_FET1_BIT]   = ctrl_reg.fet[0];
    switch_byte[mux_regs_pkg::SW_FET2_BIT]   = ctrl_reg.fet[1];
    switch_byte[mux_regs_pkg::SW_LS1_BIT]    = lstate[0];
    switch_byte[mux_regs_pkg::SW_LS2_BIT]    = lstate[1];
  end

  assign rd_data = (ptr_reg == mux_regs_pkg::REG_STATUS) ? status_byte :
                   (ptr_reg == mux_regs_pkg::REG_ACCEL)  ? accel_byte  :
                   (ptr_reg == mux_regs_pkg::REG_CONFIG) ? config_byte :
                   (ptr_reg == mux_regs_pkg::REG_SWITCH) ? switch_byte : 8'h00;
  assign tx_byte   = ara_reg ? {own_addr, 1'b0} : rd_data;
  assign wr_status = wr_stb & (ptr_reg == mux_regs_pkg::REG_STATUS);
  assign wr_switch = wr_stb & (ptr_reg == mux_regs_pkg::REG_SWITCH);

  // register writes, connection checks and timeout disconnect
  always_comb begin
    ctrl_next = ctrl_reg;
    fail_set  = 1'b0;
    if (wr_stb && ptr_reg == mux_regs_pkg::REG_ACCEL) begin
      ctrl_next.acc_up = sr_reg[mux_regs_pkg::ACC_UP_BIT];
      ctrl_next.acc_dn = sr_reg[mux_regs_pkg::ACC_DN_BIT];
    end
    if (wr_stb && ptr_reg == mux_regs_pkg::REG_CONFIG) begin
      ctrl_next.conn_any             = sr_reg[mux_regs_pkg::CFG_CONN_BIT];
      ctrl_next.mass_wr              = sr_reg[mux_regs_pkg::CFG_MASS_BIT];
      ctrl_next.stuck_timeout_sel_hi = sr_reg[mux_regs_pkg::CFG_SEL_HI_BIT];
      ctrl_next.stuck_timeout_sel_lo = sr_reg[mux_regs_pkg::CFG_SEL_LO_BIT];
    end
    if (wr_switch) begin
      for (int ch = 0; ch < 2; ch++) begin
        if (!sr_reg[ch == 0 ? mux_regs_pkg::SW_FET1_BIT : mux_regs_pkg::SW_FET2_BIT]) begin
          ctrl_next.fet[ch] = 1'b0;
        end else if (!ctrl_reg.fet[ch]) begin
          if (ctrl_reg.conn_any || lstate[ch]) begin
            ctrl_next.fet[ch] = 1'b1;
          end else begin
            fail_set = 1'b1;
          end
        end
      end
    end
    if (tmo_hit) begin
      ctrl_next.fet = 2'b00;
    end
  end

  // sticky fault flags: a new event wins over a clearing status write
  assign fail_next  = fail_set | (fail_reg & ~wr_status);
  assign latch_next = tmo_hit | (latch_reg & ~wr_status);
  assign alert_next = fail_set | tmo_hit | (alert_reg & ~(wr_status | ara_won));

  // stuck-low timer: restarts on each clock rise or when both lines are high
  assign tmo_on    = {ctrl_reg.stuck_timeout_sel_hi, ctrl_reg.stuck_timeout_sel_lo} != mux_regs_pkg::TMO_OFF;
  assign tmo_limit = ({ctrl_reg.stuck_timeout_sel_hi, ctrl_reg.stuck_timeout_sel_lo} == mux_regs_pkg::TMO_SEL_30)
                     ? TMO_W'(TMO_30_CYC - 1) :
                     ({ctrl_reg.stuck_timeout_sel_hi, ctrl_reg.stuck_timeout_sel_lo} == mux_regs_pkg::TMO_SEL_15)
                     ? TMO_W'(TMO_15_CYC - 1) : TMO_W'(TMO_7P5_CYC - 1);
  assign tmo_clr      = (scl_s & sda_s) | scl_rise;
  assign tmo_hit      = tmo_on & ~tmo_clr & ~tmo_rt_reg & (tmo_cnt_reg == tmo_limit);
  assign tmo_cnt_next = (tmo_clr | ~tmo_on | tmo_rt_reg) ? '0 : tmo_cnt_reg + TMO_W'(1);
  assign tmo_rt_next  = tmo_hit | (tmo_rt_reg & ~tmo_clr);

  always_ff @(posedge CLK_I) begin
    if (reg_rst) begin
      ctrl_reg    <= mux_regs_pkg::CTRL_RESET;
      fail_reg    <= 1'b0;
      latch_reg   <= 1'b0;
      alert_reg   <= 1'b0;
      tmo_cnt_reg <= '0;
      tmo_rt_reg  <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      fail_reg    <= fail_next;
      latch_reg   <= latch_next;
      alert_reg   <= alert_next;
      tmo_cnt_reg <= tmo_cnt_next;
      tmo_rt_reg  <= tmo_rt_next;
    end
  end

  // fault output keeps watching channel faults even while disabled
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      fault_oe_reg <= 1'b0;
    end else begin
      fault_oe_reg <= ~f1_s | ~f2_s | alert_reg;
    end
  end

  // open-drain pins only ever pull low
  assign FAULT_N_O               = 1'b0;
  assign FAULT_N_OE_O            = fault_oe_reg;
  assign READY_O                 = 1'b0;
  assign READY_OE_O              = ~|ctrl_reg.fet;
  assign UPSTREAM_DATA_LINE_O    = 1'b0;
  assign UPSTREAM_DATA_LINE_OE_O = oe_reg;
  assign CHAN_SWITCH_O           = ctrl_reg.fet;
  assign ACCEL_UP_O              = ctrl_reg.acc_up;
  assign ACCEL_DOWN_O            = ctrl_reg.acc_dn;

  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  sequence s_blocked_connect;
    en_s && wr_switch && !ctrl_reg.conn_any && sr_reg[mux_regs_pkg::SW_FET1_BIT] && !ctrl_reg.fet[0] && !lstate[0];
  endsequence
  sequence s_own_address;
    en_s && state_reg == mux_regs_pkg::ST_ADDR && !start_cond && !stop_cond && scl_fall
      && bitcnt_reg == 4'h8 && own_hit;
  endsequence

  AST_CHANNEL_FAULT: assert property ((!f1_s || !f2_s) |=> FAULT_N_OE_O)
    else $error("channel fault did not pull fault output");
  AST_STUCK_FAULT: assert property (tmo_hit && en_s ##1 en_s |=> FAULT_N_OE_O)
    else $error("stuck bus did not pull fault output");
  AST_REFUSED_CONNECT: assert property (s_blocked_connect |=> !ctrl_reg.fet[0]
      && !status_byte[mux_regs_pkg::ST_NOFAIL_BIT] ##1 (FAULT_N_OE_O || !en_s))
    else $error("low channel was connected or failure not flagged");
  AST_OVERRIDE_CONNECT: assert property (en_s && wr_switch && ctrl_reg.conn_any && !tmo_hit
      && sr_reg[mux_regs_pkg::SW_FET1_BIT] |=> ctrl_reg.fet[0] && !READY_OE_O)
    else $error("override did not connect channel one");
  AST_TIMEOUT_DISCONNECT: assert property (tmo_hit && en_s |=> READY_OE_O && ctrl_reg.fet == 2'b00
      && status_byte[mux_regs_pkg::ST_RT_BIT] && status_byte[mux_regs_pkg::ST_LATCH_BIT])
    else $error("timeout did not disconnect and flag");
  AST_DISABLED_DEFAULTS: assert property (!en_s |=> ctrl_reg == mux_regs_pkg::CTRL_RESET
      && !UPSTREAM_DATA_LINE_OE_O && !ACCEL_UP_O && !ACCEL_DOWN_O)
    else $error("registers not at defaults while disabled");
  AST_STATUS_CLEAR: assert property (en_s && wr_status && !tmo_hit && !fail_set |=> !latch_reg
      && !fail_reg && ctrl_reg == $past(ctrl_reg))
    else $error("status write did not clear faults cleanly");
  AST_ADDRESS_ACK: assert property (s_own_address ##1 en_s |-> UPSTREAM_DATA_LINE_OE_O
      && state_reg == mux_regs_pkg::ST_AACK)
    else $error("own address not acknowledged");
  AST_ALERT_RESPONSE: assert property (en_s && ara_won && !tmo_hit && !fail_set |=> !alert_reg)
    else $error("alert not released after alert response");

endmodule

// ===== tb/bus_master_model.sv
/*
  upstream two-wire master model, one bit per 160 ns.
  assumes the bench resolves the open-drain data wire into sda_i.
*/
`timescale 1ns/1ns
module bus_master_model (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // wait n system clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // data moves while clock high: start is (1,0,0), stop is (0,1,1)
  task automatic cond(input logic s0, input logic s1, input logic fin);
    sda_o <= s0;
    tick(2);
    scl_o <= 1'b1;
    tick(2);
    sda_o <= s1;
    tick(2);
    scl_o <= fin;
    tick(2);
  endtask
  // nine bits msb first, data held through the whole clock-high phase
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_o <= tx[i];
      tick(2);
      scl_o <= 1'b1;
      tick(4);
      rx[i] = sda_i;
      scl_o <= 1'b0;
      tick(2);
    end
  endtask
endmodule

// ===== tb/bus_mux_status_control_regs_test.sv
/*
  self-checking bench of the multiplexer register bank.
  assumes straps select address 7'h53 and short timeout counts.
*/
`timescale 1ns/1ns
module bus_mux_status_control_regs_test;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, f1 = 1'b1, f2 = 1'b1, d2 = 1'b1, ack;
  logic scl, sdam, sda_oe, f_oe, r_oe, up, dn;
  logic [1:0] sw;
  logic [7:0] v;
  logic c1d = 1'b1, c1c = 1'b1, c2c = 1'b1;
  logic [5:0] adr = 6'b110001;
  wire fo, ro, so;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  wire sda = sdam & ~sda_oe;
  wire [7:0] pins = {4'h0, r_oe, f_oe, sw};
  bus_master_model u_bus_master_model (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(sdam));
  bus_mux_status_control_regs #(.TMO_30_CYC(400), .TMO_15_CYC(200), .TMO_7P5_CYC(100))
    u_bus_mux_status_control_regs (.CLK_I(clk), .RESET_I(rst), .ENABLE_I(en),
    .UPSTREAM_CLOCK_LINE_I(scl), .UPSTREAM_DATA_LINE_I(sda), .UPSTREAM_DATA_LINE_O(so),
    .UPSTREAM_DATA_LINE_OE_O(sda_oe), .CHAN_ONE_FAULT_IN_N_I(f1), .CHAN_TWO_FAULT_IN_N_I(f2),
    .CHAN_ONE_DATA_LINE_I(c1d), .CHAN_ONE_CLOCK_LINE_I(c1c), .CHAN_TWO_DATA_LINE_I(d2),
    .CHAN_TWO_CLOCK_LINE_I(c2c), .SLAVE_ADDR_SELECT_I(adr), .FAULT_N_O(fo),
    .FAULT_N_OE_O(f_oe), .READY_O(ro), .READY_OE_O(r_oe), .CHAN_SWITCH_O(sw),
    .ACCEL_UP_O(up), .ACCEL_DOWN_O(dn));
  initial begin
    forever #10 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // start, address with write, pointer byte; ack keeps the address answer
  task automatic hdr(input logic [7:0] p);
    logic [8:0] r;
    u_bus_master_model.cond(1'b1, 1'b0, 1'b0);
    u_bus_master_model.xfer(9'h14d, r);
    ack = ~r[0];
    u_bus_master_model.xfer({p, 1'b1}, r);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [8:0] r;
    hdr(p);
    u_bus_master_model.xfer({d, 1'b1}, r);
    u_bus_master_model.cond(1'b0, 1'b1, 1'b1);
    u_bus_master_model.tick(6);
  endtask
  // repeated start, read one byte, master nack
  task automatic rd(input logic [7:0] p, input logic [7:0] exp);
    logic [8:0] r;
    hdr(p);
    u_bus_master_model.cond(1'b1, 1'b0, 1'b0);
    u_bus_master_model.xfer(9'h14f, r);
    u_bus_master_model.xfer(9'h1ff, r);
    u_bus_master_model.cond(1'b0, 1'b1, 1'b1);
    chk(r[8:1], exp);
  endtask
  task automatic t_defaults();
    rd(8'h00, 8'h64);
    rd(8'h01, 8'h00);
    chk(pins, 8'h08);
    chk({5'h0, fo, ro, so}, 8'h00);
  endtask
  task automatic t_boost();
    wr(8'h01, 8'hff);
    chk({6'h0, up, dn}, 8'h03);
    rd(8'h01, 8'hc0);
  endtask
  task automatic t_connect();
    wr(8'h03, 8'h80);
    chk(pins, 8'h01);
    rd(8'h00, 8'he4);
    d2 <= 1'b0;
    wr(8'h03, 8'hc0);
    chk(pins, 8'h05);
    rd(8'h00, 8'he0);
    d2 <= 1'b1;
    wr(8'h00, 8'h00);
    chk(pins, 8'h01);
    rd(8'h00, 8'he4);
  endtask
  task automatic t_fault();
    f1 <= 1'b0;
    u_bus_master_model.tick(6);
    chk(pins, 8'h05);
    rd(8'h00, 8'ha4);
    f1 <= 1'b1;
    wr(8'h00, 8'h00);
    chk(pins, 8'h01);
  endtask
  task automatic t_enable();
    en <= 1'b0;
    u_bus_master_model.tick(6);
    chk(pins, 8'h08);
    f2 <= 1'b0;
    u_bus_master_model.tick(6);
    chk(pins, 8'h0c);
    f2 <= 1'b1;
    wr(8'h01, 8'hff);
    chk({7'h0, ack}, 8'h00);
    en <= 1'b1;
    u_bus_master_model.tick(6);
    wr(8'h00, 8'h00);
    chk({7'h0, ack}, 8'h01);
    rd(8'h01, 8'h00);
  endtask
  // shortest timeout, then clock held low after a start
  task automatic t_timeout();
    wr(8'h02, 8'h07);
    u_bus_master_model.cond(1'b1, 1'b0, 1'b0);
    u_bus_master_model.tick(120);
    chk(pins, 8'h0c);
    u_bus_master_model.cond(1'b0, 1'b1, 1'b1);
    u_bus_master_model.tick(6);
    rd(8'h00, 8'h66);
    wr(8'h00, 8'h00);
    chk(pins, 8'h08);
    rd(8'h00, 8'h64);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    en <= 1'b1;
    repeat (40) @(posedge clk);
    t_defaults();
    t_boost();
    t_connect();
    t_fault();
    t_enable();
    t_timeout();
    finish_test();
  end
endmodule
